// ---- rtl/imch_top.sv ----
// Serial boot loader command handler with its receive FIFO
// How it works
// - Write start address must be word aligned, else misaligned reply.
// - Write and read byte counts must be multiples of four, else bad-length.
// - Write payload arrives UU-encoded and is decoded before storing.
// - Write refused with protection reply at protection levels two and three.
// - Read start address must be word aligned, else misaligned reply.
// - Valid read gives success reply then UU-encoded lines of memory data.
// - Read refused with protection reply at protection levels one, two and three.
// - Checksum of raw bytes after every 20 lines, restarting afterwards.
// - Lines hold at most 45 data bytes, 61 characters.
// - Short final block gets a checksum of only the bytes sent.
// - Host retry request makes the device retry_request the same block.
// - Read accepts SRAM, external bank zero and internal flash.
// - Prepare takes start, end, bank; end must not precede start.
// - Bank 0 is A, bank 1 is B; others get bad-bank reply.
// - Completed copy or erase protects its sectors again.
// - ASCII command letter, spaced decimal arguments, CR LF ending.
`timescale 1ns/1ps
`default_nettype none
`include "imch_cfg.svh"

module imch_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `IMCH_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   always_comb
   begin
      outValid = (cnt_q != '0);
      outData = mem[rp_q];
      push = inValid && inReady;
      pop = outValid && outReady;
      wp_d = push ? ((wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
      rp_d = pop ? ((rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
      cnt_d = cnt_q + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_q <= '0;
         inReady <= 1'b1;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         inReady <= cnt_d != CW'(DEPTH);
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
      if (push)
         mem[wp_q] <= inData;
   end
endmodule : imch_fifo

module imch_top #(
   parameter int NSECT = `IMCH_SECTORS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   output logic rxReady,
   output logic [7:0] txData,
   output logic txValid,
   input wire logic txReady,
   output logic memReq,
   output logic memWe,
   output logic [31:0] memAddr,
   output logic [7:0] memWdata,
   input wire logic [7:0] memRdata,
   input wire logic memAck,
   input wire logic [1:0] protLevel,
   input wire logic relockValid,
   input wire logic relockBank,
   input wire logic [31:0] relockStart,
   input wire logic [31:0] relockEnd,
   output logic [2*NSECT-1:0] preparedMask
);
   imch_pkg::imch_state_t st_q, st_d, ret_q, ret_d;
   logic [31:0] arg_q [3];
   logic [31:0] arg_d [3];
   logic [31:0] acc_q, acc_d, addr_q, addr_d, rem_q, rem_d, blkAddr_q, blkAddr_d;
   logic [31:0] blkRem_q, blkRem_d;
   logic [1:0] argN_q, argN_d, k_q, k_d, j_q, j_d;
   logic dig_q, dig_d, bad_q, bad_d, retry_request_q, retry_request_d;
   logic [7:0] cmd_q, cmd_d, c;
   logic [5:0] lineLeft_q, lineLeft_d, sx;
   logic [4:0] lines_q, lines_d;
   logic [19:0] sum_q, sum_d, num_q, num_d;
   logic [3:0] digs_q [7];
   logic [3:0] digs_d [7];
   logic [2:0] nd_q, nd_d;
   logic [23:0] sh_q, sh_d;
   logic [35:0] prod;
   logic [2*NSECT-1:0] mask_d;
   logic [7:0] txData_d, fifoData;
   logic txValid_d, memReq_d, memWe_d, fifoValid, pop, txFree;
   logic [31:0] memAddr_d;
   logic [7:0] memWdata_d;

   imch_fifo #(.WIDTH(8), .DEPTH(`IMCH_FIFO_DEPTH)) rxFifo (
      .clk(clk),
      .rst(rst),
      .inData(rxData),
      .inValid(rxValid),
      .inReady(rxReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(pop)
   );

   function automatic logic inRegion(input logic [31:0] a, input logic [31:0] n,
                                     input logic [31:0] base, input logic [32:0] size);
      inRegion = (a >= base) && ({1'b0, a - base} + {1'b0, n} <= size);
   endfunction : inRegion

   function automatic logic [7:0] uuChar(input logic [5:0] v);
      uuChar = (v == 6'h00) ? `IMCH_CH_TICK : {2'b00, v} + `IMCH_CH_SP;
   endfunction : uuChar

   always_comb
   begin
      st_d = st_q;
      ret_d = ret_q;
      arg_d = arg_q;
      acc_d = acc_q;
      addr_d = addr_q;
      rem_d = rem_q;
      blkAddr_d = blkAddr_q;
      blkRem_d = blkRem_q;
      argN_d = argN_q;
      k_d = k_q;
      j_d = j_q;
      dig_d = dig_q;
      bad_d = bad_q;
      retry_request_d = retry_request_q;
      cmd_d = cmd_q;
      lineLeft_d = lineLeft_q;
      lines_d = lines_q;
      sum_d = sum_q;
      num_d = num_q;
      digs_d = digs_q;
      nd_d = nd_q;
      sh_d = sh_q;
      memReq_d = memReq;
      memWe_d = memWe;
      memAddr_d = memAddr;
      memWdata_d = memWdata;
      txFree = !txValid || txReady;
      txValid_d = txValid && !txReady;
      txData_d = txData;
      c = fifoData;
      sx = 6'(c - `IMCH_CH_SP) & 6'(`IMCH_SEXTET_MASK);
      prod = {4'h0, acc_q} * 36'd10 + 36'(c - `IMCH_CH_0);
      pop = fifoValid && (st_q == imch_pkg::S_IDLE || st_q == imch_pkg::S_ARGS
            || st_q == imch_pkg::S_WLEN || st_q == imch_pkg::S_WCHR
            || st_q == imch_pkg::S_RACK);
      // Clear first so that a prepare in the same cycle wins
      mask_d = preparedMask;
      if (relockValid)
         for (int i = 0; i < NSECT; i++)
            if (32'(i) >= relockStart && 32'(i) <= relockEnd)
               mask_d[NSECT*relockBank + i] = 1'b0;
      case (st_q)
         imch_pkg::S_IDLE:
            if (pop && c != `IMCH_CH_CR && c != `IMCH_CH_LF)
            begin
               cmd_d = c;
               argN_d = 2'd0;
               acc_d = '0;
               dig_d = 1'b0;
               bad_d = 1'b0;
               st_d = imch_pkg::S_ARGS;
            end
         imch_pkg::S_ARGS:
            if (pop)
            begin
               if (c >= `IMCH_CH_0 && c <= `IMCH_CH_9)
               begin
                  acc_d = prod[31:0];
                  dig_d = 1'b1;
                  if (prod[35:32] != 4'h0)
                     bad_d = 1'b1;
               end
               else if (c == `IMCH_CH_SP || c == `IMCH_CH_LF)
               begin
                  if (dig_q)
                  begin
                     if (argN_q == 2'd3)
                        bad_d = 1'b1;
                     else
                     begin
                        arg_d[argN_q] = acc_q;
                        argN_d = argN_q + 2'd1;
                     end
                  end
                  acc_d = '0;
                  dig_d = 1'b0;
                  if (c == `IMCH_CH_LF)
                     st_d = imch_pkg::S_EXEC;
               end
               else if (c != `IMCH_CH_CR)
                  bad_d = 1'b1;
            end
         imch_pkg::S_EXEC:
         begin
            nd_d = 3'd0;
            ret_d = imch_pkg::S_IDLE;
            st_d = imch_pkg::S_NCONV;
            num_d = `IMCH_RC_SUCCESS;
            addr_d = arg_q[0];
            rem_d = arg_q[1];
            blkAddr_d = arg_q[0];
            blkRem_d = arg_q[1];
            sum_d = '0;
            lines_d = '0;
            if (cmd_q == `IMCH_CH_W && protLevel >= 2'd2)
               num_d = `IMCH_RC_PROTECT;
            else if (cmd_q == `IMCH_CH_R && protLevel != 2'd0)
               num_d = `IMCH_RC_PROTECT;
            else if (bad_q || (cmd_q != `IMCH_CH_W && cmd_q != `IMCH_CH_R
                     && cmd_q != `IMCH_CH_P))
               num_d = `IMCH_RC_BADPARAM;
            else if (cmd_q == `IMCH_CH_P)
            begin
               if (argN_q != 2'd3)
                  num_d = `IMCH_RC_BADPARAM;
               else if (arg_q[2] > 32'd1)
                  num_d = `IMCH_RC_BADBANK;
               else if (arg_q[1] < arg_q[0] || arg_q[1] >= 32'(NSECT))
                  num_d = `IMCH_RC_BADSECT;
               else
                  for (int i = 0; i < NSECT; i++)
                     if (32'(i) >= arg_q[0] && 32'(i) <= arg_q[1])
                        mask_d[NSECT*arg_q[2][0] + i] = 1'b1;
            end
            else if (argN_q != 2'd2)
               num_d = `IMCH_RC_BADPARAM;
            else if (arg_q[0][1:0] != 2'b00)
               num_d = `IMCH_RC_MISALIGN;
            else if (arg_q[1][1:0] != 2'b00)
               num_d = `IMCH_RC_BADLEN;
            else if (cmd_q == `IMCH_CH_W)
            begin
               if (!inRegion(arg_q[0], arg_q[1], `IMCH_SRAM_BASE, `IMCH_SRAM_SIZE))
                  num_d = `IMCH_RC_UNMAPPED;
               else if (arg_q[1] != '0)
                  ret_d = imch_pkg::S_WLEN;
            end
            else if (!(inRegion(arg_q[0], arg_q[1], `IMCH_SRAM_BASE, `IMCH_SRAM_SIZE)
                     || inRegion(arg_q[0], arg_q[1], `IMCH_EXT0_BASE, `IMCH_EXT0_SIZE)
                     || inRegion(arg_q[0], arg_q[1], `IMCH_FLASH_BASE, `IMCH_FLASH_SIZE)))
               num_d = `IMCH_RC_UNMAPPED;
            else if (arg_q[1] != '0)
               ret_d = imch_pkg::S_RLINE;
         end
         imch_pkg::S_NCONV:
         begin
            digs_d[nd_q] = 4'(num_q % 20'd10);
            num_d = num_q / 20'd10;
            nd_d = nd_q + 3'd1;
            if (num_q < 20'd10)
               st_d = imch_pkg::S_NSEND;
         end
         imch_pkg::S_NSEND:
            if (txFree)
            begin
               txValid_d = 1'b1;
               txData_d = {4'h3, digs_q[nd_q - 3'd1]};
               nd_d = nd_q - 3'd1;
               if (nd_q == 3'd1)
                  st_d = imch_pkg::S_CR;
            end
         imch_pkg::S_CR:
            if (txFree)
            begin
               txValid_d = 1'b1;
               txData_d = `IMCH_CH_CR;
               st_d = imch_pkg::S_LF;
            end
         imch_pkg::S_LF:
            if (txFree)
            begin
               txValid_d = 1'b1;
               txData_d = `IMCH_CH_LF;
               st_d = ret_q;
            end
         imch_pkg::S_WLEN:
            if (pop && c != `IMCH_CH_CR && c != `IMCH_CH_LF)
            begin
               lineLeft_d = sx;
               k_d = 2'd0;
               st_d = imch_pkg::S_WCHR;
            end
         imch_pkg::S_WCHR:
            if (pop && c == `IMCH_CH_LF)
               st_d = (rem_q == '0) ? imch_pkg::S_IDLE : imch_pkg::S_WLEN;
            else if (pop && c != `IMCH_CH_CR)
            begin
               sh_d = {sh_q[17:0], sx};
               k_d = k_q + 2'd1;
               if (k_q == `IMCH_GROUP_LAST)
               begin
                  j_d = 2'd0;
                  st_d = imch_pkg::S_WMEM;
               end
            end
         imch_pkg::S_WMEM:
            if (j_q == 2'd3 || lineLeft_q == '0 || rem_q == '0)
               st_d = imch_pkg::S_WCHR;
            else if (!memReq)
            begin
               memReq_d = 1'b1;
               memWe_d = 1'b1;
               memAddr_d = addr_q;
               memWdata_d = sh_q[23:16];
            end
            else if (memAck)
            begin
               memReq_d = 1'b0;
               sh_d = {sh_q[15:0], 8'h00};
               addr_d = addr_q + 32'd1;
               rem_d = rem_q - 32'd1;
               lineLeft_d = lineLeft_q - 6'd1;
               j_d = j_q + 2'd1;
            end
         imch_pkg::S_RLINE:
            if (rem_q == '0 || lines_q == `IMCH_LINES_PER_SUM)
            begin
               num_d = sum_q;
               nd_d = 3'd0;
               ret_d = imch_pkg::S_RACK;
               st_d = imch_pkg::S_NCONV;
            end
            else if (txFree)
            begin
               lineLeft_d = (rem_q < 32'(`IMCH_LINE_BYTES)) ? rem_q[5:0]
                            : `IMCH_LINE_BYTES;
               txValid_d = 1'b1;
               txData_d = uuChar(lineLeft_d);
               j_d = 2'd0;
               st_d = imch_pkg::S_RFET;
            end
         imch_pkg::S_RFET:
            if (j_q == 2'd3)
            begin
               k_d = 2'd0;
               st_d = imch_pkg::S_RCHR;
            end
            else if (lineLeft_q == '0)
            begin
               sh_d = {sh_q[15:0], 8'h00};
               j_d = j_q + 2'd1;
            end
            else if (!memReq)
            begin
               memReq_d = 1'b1;
               memWe_d = 1'b0;
               memAddr_d = addr_q;
            end
            else if (memAck)
            begin
               memReq_d = 1'b0;
               sh_d = {sh_q[15:0], memRdata};
               sum_d = sum_q + 20'(memRdata);
               addr_d = addr_q + 32'd1;
               rem_d = rem_q - 32'd1;
               lineLeft_d = lineLeft_q - 6'd1;
               j_d = j_q + 2'd1;
            end
         imch_pkg::S_RCHR:
            if (txFree)
            begin
               txValid_d = 1'b1;
               txData_d = uuChar(sh_q[23:18]);
               sh_d = {sh_q[17:0], 6'h00};
               k_d = k_q + 2'd1;
               if (k_q == `IMCH_GROUP_LAST)
               begin
                  j_d = 2'd0;
                  st_d = imch_pkg::S_RFET;
                  if (lineLeft_q == '0)
                  begin
                     lines_d = lines_q + 5'd1;
                     ret_d = imch_pkg::S_RLINE;
                     st_d = imch_pkg::S_CR;
                  end
               end
            end
         imch_pkg::S_RACK:
            if (pop && c == `IMCH_CH_LF)
            begin
               // A retry rewinds to the block start; anything else counts as OK
               if (retry_request_q)
               begin
                  addr_d = blkAddr_q;
                  rem_d = blkRem_q;
               end
               else
               begin
                  blkAddr_d = addr_q;
                  blkRem_d = rem_q;
               end
               sum_d = '0;
               lines_d = '0;
               retry_request_d = 1'b0;
               st_d = (!retry_request_q && rem_q == '0) ? imch_pkg::S_IDLE : imch_pkg::S_RLINE;
            end
            else if (pop && c == `IMCH_CH_R)
               retry_request_d = 1'b1;
            else if (pop && c == `IMCH_CH_O)
               retry_request_d = 1'b0;
         default:
            st_d = imch_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= imch_pkg::S_IDLE;
         ret_q <= imch_pkg::S_IDLE;
         arg_q <= '{default: '0};
         digs_q <= '{default: '0};
         acc_q <= '0;
         addr_q <= '0;
         rem_q <= '0;
         blkAddr_q <= '0;
         blkRem_q <= '0;
         argN_q <= '0;
         k_q <= '0;
         j_q <= '0;
         dig_q <= 1'b0;
         bad_q <= 1'b0;
         retry_request_q <= 1'b0;
         cmd_q <= '0;
         lineLeft_q <= '0;
         lines_q <= '0;
         sum_q <= '0;
         num_q <= '0;
         nd_q <= '0;
         sh_q <= '0;
         txData <= '0;
         txValid <= 1'b0;
         memReq <= 1'b0;
         memWe <= 1'b0;
         memAddr <= '0;
         memWdata <= '0;
         preparedMask <= '0;
      end
      else
      begin
         st_q <= st_d;
         ret_q <= ret_d;
         arg_q <= arg_d;
         digs_q <= digs_d;
         acc_q <= acc_d;
         addr_q <= addr_d;
         rem_q <= rem_d;
         blkAddr_q <= blkAddr_d;
         blkRem_q <= blkRem_d;
         argN_q <= argN_d;
         k_q <= k_d;
         j_q <= j_d;
         dig_q <= dig_d;
         bad_q <= bad_d;
         retry_request_q <= retry_request_d;
         cmd_q <= cmd_d;
         lineLeft_q <= lineLeft_d;
         lines_q <= lines_d;
         sum_q <= sum_d;
         num_q <= num_d;
         nd_q <= nd_d;
         sh_q <= sh_d;
         txData <= txData_d;
         txValid <= txValid_d;
         memReq <= memReq_d;
         memWe <= memWe_d;
         memAddr <= memAddr_d;
         memWdata <= memWdata_d;
         preparedMask <= mask_d;
      end
   end
endmodule : imch_top
`default_nettype wire

// ---- rtl/imch_cfg.svh ----
// Constants for the serial memory command handler
`ifndef IMCH_CFG_SVH
`define IMCH_CFG_SVH
`define IMCH_RC_SUCCESS 20'h00000
`define IMCH_RC_MISALIGN 20'h00001
`define IMCH_RC_BADLEN 20'h00002
`define IMCH_RC_UNMAPPED 20'h00003
`define IMCH_RC_BADPARAM 20'h00004
`define IMCH_RC_PROTECT 20'h00005
`define IMCH_RC_BADSECT 20'h00006
`define IMCH_RC_BADBANK 20'h00007
`define IMCH_CH_CR 8'h0d
`define IMCH_CH_LF 8'h0a
`define IMCH_CH_SP 8'h20
`define IMCH_CH_0 8'h30
`define IMCH_CH_9 8'h39
`define IMCH_CH_W 8'h57
`define IMCH_CH_R 8'h52
`define IMCH_CH_P 8'h50
`define IMCH_CH_O 8'h4f
`define IMCH_CH_TICK 8'h60
`define IMCH_SEXTET_MASK 8'h3f
`define IMCH_LINE_BYTES 6'h2d
`define IMCH_LINES_PER_SUM 5'h14
`define IMCH_GROUP_LAST 2'h3
`define IMCH_FIFO_DEPTH 4
`define IMCH_SRAM_BASE 32'h10000000
`define IMCH_SRAM_SIZE 33'h000020000
`define IMCH_EXT0_BASE 32'h1c000000
`define IMCH_EXT0_SIZE 33'h001000000
`define IMCH_FLASH_BASE 32'h1a000000
`define IMCH_FLASH_SIZE 33'h000080000
`define IMCH_SECTORS 16
`endif

// ---- rtl/imch_pkg.sv ----
// Types for the serial memory command handler
package imch_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_ARGS, S_EXEC, S_NCONV, S_NSEND, S_CR, S_LF,
      S_WLEN, S_WCHR, S_WMEM, S_RLINE, S_RFET, S_RCHR, S_RACK
   } imch_state_t;
endpackage : imch_pkg

// ---- test/imch_top_monitor.sv ----
// Port-level assertions for the serial command handler
`timescale 1ns/1ps
`default_nettype none
`include "imch_cfg.svh"
module imch_top_monitor #(
   parameter int NSECT = `IMCH_SECTORS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic rxReady,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [31:0] memAddr,
   input wire logic [7:0] memWdata,
   input wire logic [7:0] memRdata,
   input wire logic memAck,
   input wire logic [1:0] protLevel,
   input wire logic relockValid,
   input wire logic relockBank,
   input wire logic [31:0] relockStart,
   input wire logic [31:0] relockEnd,
   input wire logic [2*NSECT-1:0] preparedMask
);
   logic [32:0] a;
   logic inSram, inExt, inFlash;
   assign a = {1'b0, memAddr};
   assign inSram = a >= `IMCH_SRAM_BASE && a < `IMCH_SRAM_BASE + `IMCH_SRAM_SIZE;
   assign inExt = a >= `IMCH_EXT0_BASE && a < `IMCH_EXT0_BASE + `IMCH_EXT0_SIZE;
   assign inFlash = a >= `IMCH_FLASH_BASE && a < `IMCH_FLASH_BASE + `IMCH_FLASH_SIZE;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   reset_idle_a: assert property ($fell(rst) |-> !txValid && !memReq && rxReady
      && preparedMask == '0) else $error("outputs not idle after reset");
   tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("reply byte dropped or changed before taken");
   mem_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
      && $stable(memWe)) else $error("memory request changed before ack");
   mem_gap_a: assert property (memReq && memAck |=> !memReq)
      else $error("memory request not dropped after ack");
   write_prot_a: assert property (memReq && memWe |-> protLevel < 2'h2)
      else $error("memory write under write-blocking protection");
   read_prot_a: assert property (memReq && !memWe |-> protLevel == 2'h0)
      else $error("memory read under protection");
   mem_mapped_a: assert property (memReq |-> (memWe ? inSram : inSram || inExt || inFlash))
      else $error("memory access outside mapped region");
   relock_clear_a: assert property (relockValid && !relockBank && relockStart == 0
      && relockEnd == NSECT - 1 |=> preparedMask[NSECT-1:0] == '0)
      else $error("relocked sectors still prepared");
endmodule : imch_top_monitor
bind imch_top imch_top_monitor #(.NSECT(NSECT)) u_monitor (.clk(clk), .rst(rst),
   .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
   .txValid(txValid), .txReady(txReady), .memReq(memReq), .memWe(memWe),
   .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
   .protLevel(protLevel), .relockValid(relockValid), .relockBank(relockBank),
   .relockStart(relockStart), .relockEnd(relockEnd), .preparedMask(preparedMask));
`default_nettype wire

// ---- test/imch_mem_model.sv ----
// Byte memory partner answering the handler's request port
`timescale 1ns/1ps
`default_nettype none
module imch_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [31:0] memAddr,
   input wire logic [7:0] memWdata,
   output logic [7:0] memRdata,
   output logic memAck
);
   logic [7:0] store [64];
   logic [1:0] cnt;
   // Small store aliases every 64 bytes; the bench mirrors the same folding
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         memAck <= 1'b0;
         cnt <= 2'h0;
         for (int i = 0; i < 64; i++) store[i] <= 8'(i * 7 + 19);
      end
      else if (memAck)
      begin
         memAck <= 1'b0;
         cnt <= 2'h0;
         // Released data turns over so a late sample never looks valid
         memRdata <= ~memRdata;
      end
      else if (memReq)
      begin
         if (cnt >= (slow ? 2'h3 : 2'h0))
         begin
            memAck <= 1'b1;
            if (memWe) store[memAddr[5:0]] <= memWdata;
            else memRdata <= store[memAddr[5:0]];
         end
         else cnt <= cnt + 2'h1;
      end
   end
endmodule : imch_mem_model
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the serial command handler
`timescale 1ns/1ps
`default_nettype none
`include "imch_cfg.svh"
module testbench;
   logic clk, rst, rxValid, txReady, relockValid, relockBank, slow;
   logic txValid, rxReady, memReq, memWe, memAck;
   logic [7:0] rxData, txData, memWdata, memRdata;
   logic [31:0] memAddr, relockStart, relockEnd, preparedMask;
   logic [1:0] protLevel;
   logic [7:0] expMem [64];
   int n_mismatch = 0;
   int checks = 0;
   int nAcc = 0;
   imch_top DUT (.clk(clk), .rst(rst), .rxData(rxData), .rxValid(rxValid),
      .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
      .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck), .protLevel(protLevel),
      .relockValid(relockValid), .relockBank(relockBank), .relockStart(relockStart),
      .relockEnd(relockEnd), .preparedMask(preparedMask));
   imch_mem_model mem (.clk(clk), .rst(rst), .slow(slow), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task stuck;
      chk(32'h0, 32'h1);
      print_verdict;
   endtask : stuck
   task send_str(input string s, input int lim);
      int w;
      for (int i = 0; i < s.len(); i++)
      begin
         rxData <= s[i];
         rxValid <= 1'b1;
         for (w = 0; w < lim; w++)
         begin
            @(posedge clk);
            if (rxReady === 1'b1) break;
         end
         if (w == lim) stuck;
         nAcc++;
      end
      rxValid <= 1'b0;
   endtask : send_str
   task expect_line(input string exp);
      string got, e;
      int w;
      got = "";
      e = {exp, "\r\n"};
      for (w = 0; w < 400; w++)
      begin
         @(posedge clk);
         if (txValid === 1'b1)
         begin
            got = {got, $sformatf("%c", txData)};
            if (txData === `IMCH_CH_LF) break;
         end
      end
      if (w == 400) stuck;
      if (got.len() != e.len()) chk(got.len(), e.len());
      else foreach (e[i]) if (got[i] != e[i]) chk(got[i], e[i]);
      checks++;
   endtask : expect_line
   function automatic logic [7:0] uc(logic [5:0] v);
      return (v == 6'h0) ? `IMCH_CH_TICK : {2'h0, v} + 8'h20;
   endfunction : uc
   function automatic string enc(int base, int n);
      string s;
      logic [23:0] w;
      s = $sformatf("%c", n + 32);
      for (int i = 0; i < n; i += 3)
      begin
         for (int j = 0; j < 3; j++) w[23-8*j -: 8] = (i + j < n) ? expMem[(base+i+j)%64] : 8'h0;
         for (int j = 3; j >= 0; j--) s = {s, $sformatf("%c", uc(w[j*6 +: 6]))};
      end
      return s;
   endfunction : enc
   task read_check(input logic [31:0] addr, input int n, input bit again);
      int pos, blk, m, sum, base;
      base = addr[5:0];
      send_str($sformatf("R %0d %0d\r\n", addr, n), 50);
      expect_line("0");
      pos = 0;
      while (pos < n)
      begin
         blk = pos;
         sum = 0;
         for (int l = 0; l < 20 && pos < n; l++)
         begin
            m = (n - pos > 45) ? 45 : n - pos;
            expect_line(enc(base + pos, m));
            for (int k = 0; k < m; k++) sum += expMem[(base+pos+k)%64];
            pos += m;
         end
         expect_line($sformatf("%0d", sum));
         if (again) send_str("RETRY\r\n", 50);
         else send_str("OK\r\n", 50);
         if (again) pos = blk;
         again = 1'b0;
      end
   endtask : read_check
   task t_prepare_fifo;
      int w;
      txReady <= 1'b0;
      send_str("P 0 0 0\r\n", 50);
      for (w = 0; w < 50; w++)
      begin
         @(posedge clk);
         if (txValid === 1'b1) break;
      end
      if (w == 50) stuck;
      nAcc = 0;
      fork
         send_str("P 1 1 0\r\n", 400);
         begin
            repeat (20) @(posedge clk);
            chk(nAcc, `IMCH_FIFO_DEPTH);
            txReady <= 1'b1;
            expect_line("0");
            expect_line("0");
         end
      join
      @(posedge clk);
      chk(preparedMask, 32'h3);
   endtask : t_prepare_fifo
   task t_errors;
      string c[16] = '{"W 268435969 4", "W 268435968 6", "R 268435970 4", "R 268435968 10",
         "W 0 4", "R 4 4", "W 436207616 4", "W 268435968", "X 1 2", "W 268435968 4",
         "W 268435968 4", "R 268435968 4", "P 3 2 0", "P 1 1 2", "P 0 16 0", "P 2 2 1"};
      logic [19:0] rc[16] = '{`IMCH_RC_MISALIGN, `IMCH_RC_BADLEN, `IMCH_RC_MISALIGN,
         `IMCH_RC_BADLEN, `IMCH_RC_UNMAPPED, `IMCH_RC_UNMAPPED, `IMCH_RC_UNMAPPED,
         `IMCH_RC_BADPARAM, `IMCH_RC_BADPARAM, `IMCH_RC_PROTECT, `IMCH_RC_PROTECT,
         `IMCH_RC_PROTECT, `IMCH_RC_BADSECT, `IMCH_RC_BADBANK, `IMCH_RC_BADSECT,
         `IMCH_RC_SUCCESS};
      logic [1:0] pl[16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 3, 1, 0, 0, 0, 0};
      foreach (c[i])
      begin
         protLevel <= pl[i];
         @(posedge clk);
         send_str({c[i], "\r\n"}, 50);
         expect_line($sformatf("%0d", rc[i]));
      end
      protLevel <= 2'h0;
      @(posedge clk);
      chk(preparedMask, 32'h00040003);
   endtask : t_errors
   task t_relock;
      relockValid <= 1'b1;
      relockEnd <= 32'hf;
      @(posedge clk);
      relockValid <= 1'b0;
      repeat (2) @(posedge clk);
      chk(preparedMask, 32'h00040000);
   endtask : t_relock
   task t_write_back;
      for (int i = 0; i < 4; i++) expMem[i] = 8'h11 * (i + 1);
      send_str("W 268435968 4\r\n", 50);
      expect_line("0");
      send_str({enc(0, 4), "\r\n"}, 100);
      repeat (10) @(posedge clk);
      read_check(32'h10000200, 4, 1'b0);
   endtask : t_write_back
   initial
   begin
      rst = 1'b1;
      rxData = 8'h0;
      rxValid = 1'b0;
      txReady = 1'b1;
      protLevel = 2'h0;
      relockValid = 1'b0;
      relockBank = 1'b0;
      relockStart = 32'h0;
      relockEnd = 32'h0;
      slow = 1'b0;
      for (int i = 0; i < 64; i++) expMem[i] = 8'(i * 7 + 19);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_prepare_fifo;
      t_errors;
      t_relock;
      slow <= 1'b1;
      read_check(32'h1c000000, 908, 1'b1);
      t_write_back;
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
